// ===== design/pio_pkg.sv
// Shared constants and types for the programmed-I/O endpoint and its host end.
// Assumes one 200 MHz clock with a synchronous active-low reset on both ends.
// Behaviour
// [RL1] Host issues only single-dword reads and writes
// [RL2] Packets become plain memory reads and writes
// [RL3] Every received packet reaches application over stream
// [RL4] Memory external up to x8, internal otherwise; code selects by INTERNAL_MEM, not by lane count
// [RL5] Self test writes, reads back 0x40, compares
// [RL6] Debug buses exist only when option enabled; code keeps them, driven to zero, when DEBUG_EN is off
// [RL7] Status: speed, training state, completion credits
// [RL8] Status bits 2-8 carry error flags
// [RL9] Status bits 9-22 carry link events, lanes
// [RL10] Bit 48 buffer overflow, bit 49 reset
// [RL11] Test control low word at typical values
// [RL12] Test control bits 255:32 held zero
// [RL13] Link widths 1, 2, 4 or 8 lanes
// [RL14] Endpoint application has no registers of its own
// [RL15] Each read returns one matching completion
package pio_pkg;
	// Timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int TICK_128_NS = 128;
	localparam int TICK_US_NS = 1000;
	localparam int TICK_128_CYC = TICK_128_NS / CLK_PERIOD_NS;
	localparam int TICK_US_CYC = TICK_US_NS / CLK_PERIOD_NS;
	// Status bus field positions
	localparam int SB_SPEED = 0;
	localparam int SB_COR_RCV = 2;
	localparam int SB_COR_RPL = 3;
	localparam int SB_DERR = 4;
	localparam int SB_RX_PAR = 5;
	localparam int SB_TX_PAR = 6;
	localparam int SB_CFG_PAR = 8;
	localparam int SB_DLUP = 9;
	localparam int SB_DLUP_EXIT = 10;
	localparam int SB_TICK_128 = 11;
	localparam int SB_TICK_US = 12;
	localparam int SB_HOTRST_EXIT = 13;
	localparam int SB_INT_STATUS = 14;
	localparam int SB_L2_EXIT = 18;
	localparam int SB_LANE_ACT = 19;
	localparam int SB_LTSSM = 23;
	localparam int SB_CPL_HDR = 28;
	localparam int SB_CPL_DATA = 36;
	localparam int SB_CPL_OVF = 48;
	localparam int SB_RESET = 49;
	localparam int SB_USED = 50;
	// Typical test control values
	localparam logic [0:0] TC_BIT0 = 1'h0;
	localparam logic [3:0] TC_BITS4_1 = 4'h4;
	localparam logic [1:0] TC_BITS6_5 = 2'h1;
	localparam logic [24:0] TC_BITS31_7 = 25'h0000003;
	// Host register offsets
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_MASK = 8'h14;
	localparam logic [7:0] REG_DBG_LO = 8'h18;
	localparam logic [7:0] REG_DBG_HI = 8'h1C;
	// Command and status bits
	localparam int CMD_WRITE = 0;
	localparam int CMD_READ = 1;
	localparam int CMD_TEST = 2;
	localparam int STS_DONE = 0;
	localparam int STS_PASS = 1;
	localparam int STS_FAIL = 2;
	localparam int STS_BUSY = 3;
	localparam logic [31:0] TEST_ADDR = 32'h00000040;
	localparam logic [2:0] STS_RESET = 3'h0;
	// Link-layer state handed in by the core
	typedef struct packed {
		logic [1:0] speed;
		logic cor_rcv;
		logic cor_rpl;
		logic derr;
		logic rx_par;
		logic [1:0] tx_par;
		logic cfg_par;
		logic dlup;
		logic dlup_exit;
		logic hotrst_exit;
		logic [3:0] int_status;
		logic l2_exit;
		logic [4:0] ltssm;
		logic cpl_ovf;
	} core_status_type;
endpackage : pio_pkg

// ===== design/pio_link_if.sv
// Transaction link between host end and endpoint, plus the debug conduit.
// Assumes both ends share clk; the bench ties the two modports together.
interface pio_link_if;
	// Request packets, host to endpoint
	logic req_valid;
	logic req_ready;
	logic req_write;
	logic [31:0] req_addr;
	logic [31:0] req_data;
	logic [7:0] req_tag;
	logic [15:0] req_id;
	// Completion packets, endpoint to host
	logic cpl_valid;
	logic cpl_ready;
	logic [31:0] cpl_data;
	logic [7:0] cpl_tag;
	logic [15:0] cpl_id;
	// Debug conduit
	logic [255:0] test_ctrl;
	logic [255:0] dbg_status;
	modport device (input req_valid, req_write, req_addr, req_data, req_tag, req_id,
		cpl_ready, test_ctrl, output req_ready, cpl_valid, cpl_data, cpl_tag,
		cpl_id, dbg_status);
	modport host (output req_valid, req_write, req_addr, req_data, req_tag, req_id,
		cpl_ready, test_ctrl, input req_ready, cpl_valid, cpl_data, cpl_tag,
		cpl_id, dbg_status);
endinterface : pio_link_if

// ===== design/pio_memory.sv
// Separate dword memory with one-cycle registered read.
// Assumes one write or read per cycle from a single master.
module pio_memory #(
	parameter int AW = 10
) (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [31:0] wdata_i,
	output logic [31:0] rdata_o
);
	logic [31:0] mem [2**AW];

	// Write-first is not needed: reads and writes never share a cycle
	always_ff @(posedge clk_i)
	begin
		if (we_i)
		begin
			mem[addr_i] <= wdata_i;
		end
		rdata_o <= mem[addr_i];
	end
endmodule : pio_memory

// ===== design/pio_endpoint.sv
// Endpoint application end: takes request packets, accesses memory, returns
// completions, and builds the debug status bus.
// Assumes the host keeps to single-dword requests and holds a packet until taken.
module pio_endpoint #(
	parameter int AW = 10,
	parameter int LANES = 8,
	parameter bit INTERNAL_MEM = 1'b0,
	parameter bit DEBUG_EN = 1'b1,
	parameter logic [7:0] CPL_HDR_CREDIT = 8'h10,
	parameter logic [11:0] CPL_DATA_CREDIT = 12'h100
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	pio_link_if.device link,
	input pio_pkg::core_status_type core_status_i,
	output logic [31:0] test_in_o
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_READ = 2'b01,
		ST_CPL = 2'b10
	} dev_state_type;

	typedef struct packed {
		dev_state_type st;
		logic req_ready;
		logic cpl_valid;
		logic [31:0] cpl_data;
		logic [7:0] cpl_tag;
		logic [15:0] cpl_id;
		logic [7:0] cnt_128;
		logic [7:0] cnt_us;
		logic [255:0] status;
		logic [31:0] test_in;
	} dev_type;

	localparam logic [7:0] CNT_128_LAST = 8'(pio_pkg::TICK_128_CYC - 1);
	localparam logic [7:0] CNT_US_LAST = 8'(pio_pkg::TICK_US_CYC - 1);
	localparam logic [3:0] LANE_ACT = 4'(LANES);

	dev_type dev_reg;
	dev_type dev_next;
	logic accept;
	logic mem_we;
	logic [AW-1:0] mem_addr;
	logic [31:0] mem_rdata;
	logic tick_128_nanosecond;
	logic tick_us;

	// Unsupported lane counts are flagged by an error at start; the build still goes ahead
	initial
	begin
		if (!(LANES == 1 || LANES == 2 || LANES == 4 || LANES == 8)) // RL13
		begin
			$error("Unsupported lane count");
		end
	end

	// A packet is taken whenever ready is offered
	assign accept = link.req_valid && dev_reg.req_ready; // RL3
	assign mem_we = accept && link.req_write; // RL2
	assign mem_addr = link.req_addr[AW+1:2]; // RL2

	// Storage placement follows the INTERNAL_MEM option, not the lane count
	generate
		if (INTERNAL_MEM)
		begin : g_int_mem
			logic [31:0] store [2**AW];
			logic [31:0] rd_q;
			always_ff @(posedge clk_i)
			begin
				if (mem_we)
				begin
					store[mem_addr] <= link.req_data;
				end
				rd_q <= store[mem_addr];
			end
			assign mem_rdata = rd_q; // RL4
		end
		else
		begin : g_ext_mem
			pio_memory #(.AW(AW)) u_mem (
				.clk_i(clk_i),
				.we_i(mem_we),
				.addr_i(mem_addr),
				.wdata_i(link.req_data),
				.rdata_o(mem_rdata)
			); // RL4
		end
	endgenerate

	// Free-running event ticks for the status bus
	assign tick_128_nanosecond = (dev_reg.cnt_128 == CNT_128_LAST);
	assign tick_us = (dev_reg.cnt_us == CNT_US_LAST);

	// Next-state logic; no software registers exist on this end
	always_comb
	begin
		dev_next = dev_reg; // RL14
		dev_next.cnt_128 = tick_128_nanosecond ? 8'h00 : dev_reg.cnt_128 + 8'h01;
		dev_next.cnt_us = tick_us ? 8'h00 : dev_reg.cnt_us + 8'h01;
		unique case (dev_reg.st)
			ST_IDLE:
			begin
				// Writes finish at once, so they may follow back to back
				if (accept && !link.req_write)
				begin
					dev_next.req_ready = 1'b0;
					dev_next.cpl_tag = link.req_tag; // RL15
					dev_next.cpl_id = link.req_id; // RL15
					dev_next.st = ST_READ;
				end
			end
			ST_READ:
			begin
				dev_next.cpl_data = mem_rdata; // RL15
				dev_next.cpl_valid = 1'b1; // RL15
				dev_next.st = ST_CPL;
			end
			ST_CPL:
			begin
				// Completion held until the host takes it
				if (link.cpl_ready)
				begin
					dev_next.cpl_valid = 1'b0;
					dev_next.req_ready = 1'b1;
					dev_next.st = ST_IDLE;
				end
			end
		endcase
		// Debug conduit, tied to zero when the option is off
		dev_next.status = '0;
		dev_next.test_in = '0;
		if (DEBUG_EN) // RL6
		begin
			dev_next.test_in = link.test_ctrl[31:0]; // RL6
			dev_next.status[pio_pkg::SB_SPEED +: 2] = core_status_i.speed; // RL7
			dev_next.status[pio_pkg::SB_LTSSM +: 5] = core_status_i.ltssm; // RL7
			dev_next.status[pio_pkg::SB_CPL_HDR +: 8] = CPL_HDR_CREDIT; // RL7
			dev_next.status[pio_pkg::SB_CPL_DATA +: 12] = CPL_DATA_CREDIT; // RL7
			dev_next.status[pio_pkg::SB_COR_RCV] = core_status_i.cor_rcv; // RL8
			dev_next.status[pio_pkg::SB_COR_RPL] = core_status_i.cor_rpl; // RL8
			dev_next.status[pio_pkg::SB_DERR] = core_status_i.derr; // RL8
			dev_next.status[pio_pkg::SB_RX_PAR] = core_status_i.rx_par; // RL8
			dev_next.status[pio_pkg::SB_TX_PAR +: 2] = core_status_i.tx_par; // RL8
			dev_next.status[pio_pkg::SB_CFG_PAR] = core_status_i.cfg_par; // RL8
			dev_next.status[pio_pkg::SB_DLUP] = core_status_i.dlup; // RL9
			dev_next.status[pio_pkg::SB_DLUP_EXIT] = core_status_i.dlup_exit; // RL9
			dev_next.status[pio_pkg::SB_TICK_128] = tick_128_nanosecond; // RL9
			dev_next.status[pio_pkg::SB_TICK_US] = tick_us; // RL9
			dev_next.status[pio_pkg::SB_HOTRST_EXIT] = core_status_i.hotrst_exit; // RL9
			dev_next.status[pio_pkg::SB_INT_STATUS +: 4] = core_status_i.int_status; // RL9
			dev_next.status[pio_pkg::SB_L2_EXIT] = core_status_i.l2_exit; // RL9
			dev_next.status[pio_pkg::SB_LANE_ACT +: 4] = LANE_ACT; // RL9
			dev_next.status[pio_pkg::SB_CPL_OVF] = core_status_i.cpl_ovf; // RL10
			// Reset flag drops on the first edge after release
			dev_next.status[pio_pkg::SB_RESET] = 1'b0; // RL10
		end
	end

	// State register; reset holds the reset flag up on the status bus
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			dev_reg <= '0;
			dev_reg.st <= ST_IDLE;
			dev_reg.req_ready <= 1'b1;
			dev_reg.status[pio_pkg::SB_RESET] <= DEBUG_EN; // RL10
		end
		else
		begin
			dev_reg <= dev_next;
		end
	end

	// All outputs straight from flops
	assign link.req_ready = dev_reg.req_ready;
	assign link.cpl_valid = dev_reg.cpl_valid;
	assign link.cpl_data = dev_reg.cpl_data;
	assign link.cpl_tag = dev_reg.cpl_tag;
	assign link.cpl_id = dev_reg.cpl_id;
	assign link.dbg_status = dev_reg.status;
	assign test_in_o = dev_reg.test_in;
endmodule : pio_endpoint

// ===== design/pio_host.sv
// Host end: APB-programmed controller that issues single-dword requests,
// collects completions, runs the read-back test and drives test control.
// Assumes an APB master on the bus side and the endpoint on the link side.
module pio_host #(
	parameter logic [15:0] REQ_ID = 16'h0100
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic irq_o,
	pio_link_if.host link
);
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_SEND = 2'b01,
		H_WAIT = 2'b10
	} host_state_type;

	typedef struct packed {
		host_state_type st;
		logic test;
		logic req_valid;
		logic req_write;
		logic [31:0] req_addr;
		logic [7:0] tag;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic [2:0] sts;
		logic [2:0] mask;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic irq;
	} host_type;

	host_type h_reg;
	host_type h_next;
	logic wr_fire;
	logic [2:0] set;
	logic [31:0] rd_mux;
	logic mapped;

	// Write lands on the edge where pready is seen
	assign wr_fire = psel_i && penable_i && h_reg.pready && pwrite_i;

	// Read mux and decode
	always_comb
	begin
		mapped = 1'b1;
		rd_mux = 32'h00000000;
		unique case (paddr_i)
			pio_pkg::REG_CMD: rd_mux = 32'h00000000;
			pio_pkg::REG_ADDR: rd_mux = h_reg.addr;
			pio_pkg::REG_WDATA: rd_mux = h_reg.wdata;
			pio_pkg::REG_RDATA: rd_mux = h_reg.rdata;
			pio_pkg::REG_STATUS: rd_mux = {28'h0000000, h_reg.st != H_IDLE, h_reg.sts};
			pio_pkg::REG_MASK: rd_mux = {29'h00000000, h_reg.mask};
			pio_pkg::REG_DBG_LO: rd_mux = link.dbg_status[31:0];
			pio_pkg::REG_DBG_HI: rd_mux = {14'h0000, link.dbg_status[49:32]};
			default: mapped = 1'b0;
		endcase
	end

	always_comb
	begin
		h_next = h_reg;
		set = 3'h0;
		// Two-cycle access: pready rises one cycle into the access phase
		h_next.pready = psel_i && penable_i && !h_reg.pready;
		h_next.pslverr = psel_i && penable_i && !h_reg.pready && !mapped;
		if (psel_i && penable_i && !h_reg.pready)
		begin
			h_next.prdata = pwrite_i ? 32'h00000000 : rd_mux;
		end
		if (wr_fire && paddr_i == pio_pkg::REG_ADDR)
		begin
			h_next.addr = {pwdata_i[31:2], 2'b00};
		end
		if (wr_fire && paddr_i == pio_pkg::REG_WDATA)
		begin
			h_next.wdata = pwdata_i;
		end
		if (wr_fire && paddr_i == pio_pkg::REG_MASK)
		begin
			h_next.mask = pwdata_i[2:0];
		end
		unique case (h_reg.st)
			H_IDLE:
			begin
				// Commands while busy are dropped
				if (wr_fire && paddr_i == pio_pkg::REG_CMD && pwdata_i[2:0] != 3'h0)
				begin
					h_next.req_valid = 1'b1; // RL1
					h_next.test = pwdata_i[pio_pkg::CMD_TEST];
					h_next.req_write = !pwdata_i[pio_pkg::CMD_READ];
					h_next.req_addr = pwdata_i[pio_pkg::CMD_TEST] ? pio_pkg::TEST_ADDR : h_reg.addr; // RL5
					h_next.st = H_SEND;
				end
			end
			H_SEND:
			begin
				if (link.req_ready)
				begin
					h_next.req_valid = 1'b0;
					h_next.tag = h_reg.tag + 8'h01;
					if (!h_reg.req_write)
					begin
						h_next.st = H_WAIT;
					end
					else if (h_reg.test)
					begin
						// Test follows its write with the read-back
						h_next.req_valid = 1'b1; // RL5
						h_next.req_write = 1'b0;
						h_next.st = H_SEND;
					end
					else
					begin
						set[pio_pkg::STS_DONE] = 1'b1;
						h_next.st = H_IDLE;
					end
				end
			end
			H_WAIT:
			begin
				if (link.cpl_valid)
				begin
					h_next.rdata = link.cpl_data;
					set[pio_pkg::STS_DONE] = 1'b1;
					set[pio_pkg::STS_PASS] = h_reg.test && link.cpl_data == h_reg.wdata; // RL5
					set[pio_pkg::STS_FAIL] = h_reg.test && link.cpl_data != h_reg.wdata; // RL5
					h_next.st = H_IDLE;
				end
			end
			default: h_next.st = H_IDLE;
		endcase
		// Set wins over a write-one-to-clear in the same cycle
		if (wr_fire && paddr_i == pio_pkg::REG_STATUS)
		begin
			h_next.sts = h_reg.sts & ~pwdata_i[2:0];
		end
		h_next.sts = h_next.sts | set;
		h_next.irq = |(h_next.sts & h_next.mask);
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			h_reg <= '0;
			h_reg.st <= H_IDLE;
			h_reg.sts <= pio_pkg::STS_RESET;
		end
		else
		begin
			h_reg <= h_next;
		end
	end

	// Link outputs; only single-dword requests ever leave this end
	assign link.req_valid = h_reg.req_valid; // RL1
	assign link.req_write = h_reg.req_write;
	assign link.req_addr = h_reg.req_addr;
	assign link.req_data = h_reg.wdata;
	assign link.req_tag = h_reg.tag;
	assign link.req_id = REQ_ID;
	assign link.cpl_ready = (h_reg.st == H_WAIT);
	// Typical test control pattern, upper bits held at zero
	assign link.test_ctrl = {224'h0, pio_pkg::TC_BITS31_7, pio_pkg::TC_BITS6_5,
		pio_pkg::TC_BITS4_1, pio_pkg::TC_BIT0}; // RL11 RL12
	assign prdata_o = h_reg.prdata;
	assign pready_o = h_reg.pready;
	assign pslverr_o = h_reg.pslverr;
	assign irq_o = h_reg.irq;
endmodule : pio_host

// ===== bench/pio_link_sva.sv
// Checker for the link between the host end and the endpoint end.
// Assumes it sits beside the link interface, on the same clock and reset.
module pio_link_sva #(
	parameter int LANES = 8,
	parameter logic [7:0] CPL_HDR_CREDIT = 8'h10,
	parameter logic [11:0] CPL_DATA_CREDIT = 12'h100
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic req_write,
	input wire logic [7:0] req_tag,
	input wire logic [15:0] req_id,
	input wire logic cpl_valid,
	input wire logic cpl_ready,
	input wire logic [31:0] cpl_data,
	input wire logic [7:0] cpl_tag,
	input wire logic [15:0] cpl_id,
	input wire logic [255:0] dbg_status
);
	logic rd_take;
	logic [23:0] rd_reg;
	// Tag and requester of the last read taken, kept for the completion
	assign rd_take = req_valid && req_ready && !req_write;
	always_ff @(posedge clk_i)
	begin
		if (rd_take)
			rd_reg <= {req_tag, req_id};
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_reserved_zero: assert property (dbg_status[255:50] == '0)
		else $error("reserved status bits not zero");
	a_credit_fields: assert property ($past(rst_n_i) |->
		dbg_status[47:28] == {CPL_DATA_CREDIT, CPL_HDR_CREDIT}) else $error("credit fields wrong");
	a_lane_count: assert property ($past(rst_n_i) |-> dbg_status[22:19] == 4'(LANES))
		else $error("active lane field wrong");
	a_reset_flag: assert property ($past(rst_n_i) |-> !dbg_status[49])
		else $error("reset flag still set");
	a_cpl_latency: assert property (rd_take |-> ##[2:3] cpl_valid)
		else $error("completion late");
	a_cpl_hold: assert property (cpl_valid && !cpl_ready |=>
		cpl_valid && $stable({cpl_data, cpl_tag, cpl_id})) else $error("completion not held");
	a_cpl_match: assert property (cpl_valid |-> {cpl_tag, cpl_id} == rd_reg)
		else $error("completion tag or id wrong");
	a_read_blocks: assert property (rd_take |=> !req_ready [*2])
		else $error("request taken during read");
	a_one_cpl: assert property (cpl_valid && cpl_ready |=> !cpl_valid && req_ready)
		else $error("completion repeated or ready not back");
endmodule : pio_link_sva

// ===== bench/pio_endpoint_debug_conduit_tb.sv
// Testbench: host end and endpoint end joined by the link interface.
// Assumes the design files and the link checker are compiled before it.
module pio_endpoint_debug_conduit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LANES = 4;
	localparam logic [7:0] HDR = 8'h2C;
	localparam logic [11:0] DAT = 12'h3B5;
	logic clk_i;
	logic rst_n_i;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic [31:0] test_in;
	logic [31:0] v;
	pio_pkg::core_status_type cs;
	int bad_count;
	int comparisons;
	pio_link_if pio_link_if_inst ();
	pio_endpoint #(.LANES(LANES), .CPL_HDR_CREDIT(HDR), .CPL_DATA_CREDIT(DAT)) pio_endpoint_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .link(pio_link_if_inst.device),
		.core_status_i(cs), .test_in_o(test_in));
	pio_host pio_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
		.link(pio_link_if_inst.host));
	pio_link_sva #(.LANES(LANES), .CPL_HDR_CREDIT(HDR), .CPL_DATA_CREDIT(DAT)) pio_link_sva_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid(pio_link_if_inst.req_valid),
		.req_ready(pio_link_if_inst.req_ready), .req_write(pio_link_if_inst.req_write),
		.req_tag(pio_link_if_inst.req_tag), .req_id(pio_link_if_inst.req_id),
		.cpl_valid(pio_link_if_inst.cpl_valid), .cpl_ready(pio_link_if_inst.cpl_ready),
		.cpl_data(pio_link_if_inst.cpl_data), .cpl_tag(pio_link_if_inst.cpl_tag),
		.cpl_id(pio_link_if_inst.cpl_id), .dbg_status(pio_link_if_inst.dbg_status));
	// 200 MHz clock
	initial
	begin
		clk_i = 1'h0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk_word
	task automatic chk_bus(input logic [255:0] got, input logic [255:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk_bus
	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge clk_i);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'h1;
		for (n = 0; n < 20 && pready !== 1'h1; n++)
			@(posedge clk_i);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1)
		begin
			bad_count++;
			final_report();
		end
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'h1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'h0, a, 32'h00000000, r, e);
	endtask : rd
	// Clear sticky bits, start a command, poll for done under a bound
	task automatic run_cmd(input logic [31:0] cmd);
		logic [31:0] s;
		int n;
		wr(pio_pkg::REG_STATUS, 32'h00000007);
		wr(pio_pkg::REG_CMD, cmd);
		s = '0;
		for (n = 0; n < 40 && s[0] !== 1'h1; n++)
			rd(pio_pkg::REG_STATUS, s);
		if (s[0] !== 1'h1)
		begin
			bad_count++;
			final_report();
		end
	endtask : run_cmd
	function automatic logic [255:0] exp_status(input pio_pkg::core_status_type c);
		logic [255:0] e;
		e = '0;
		e[5:0] = {c.rx_par, c.derr, c.cor_rpl, c.cor_rcv, c.speed};
		e[10:6] = {c.dlup_exit, c.dlup, c.cfg_par, c.tx_par};
		e[18:13] = {c.l2_exit, c.int_status, c.hotrst_exit};
		e[22:19] = 4'(LANES);
		e[27:23] = c.ltssm;
		e[48:28] = {c.cpl_ovf, DAT, HDR};
		return e;
	endfunction : exp_status
	// Two opposite field patterns; tick bits masked out here
	task automatic t_conduit;
		logic [255:0] e;
		int k;
		for (k = 0; k < 2; k++)
		begin
			cs <= pio_pkg::core_status_type'(k ? 23'h2AAAAA : 23'h555555);
			repeat (3) @(posedge clk_i);
			e = exp_status(cs);
			chk_bus(pio_link_if_inst.dbg_status & ~256'h1800, e, "status");
			rd(pio_pkg::REG_DBG_HI, v);
			chk_word(v, {14'h0, e[49:32]}, "dbg hi");
			rd(pio_pkg::REG_DBG_LO, v);
			chk_word(v & ~32'h00001800, e[31:0], "dbg lo");
		end
		chk_word(test_in, {25'h3, 2'b01, 4'b0100, 1'b0}, "test in");
		chk_bus(pio_link_if_inst.test_ctrl, {224'h0, 25'h3, 7'h28}, "test ctrl");
		$display("conduit test done");
	endtask : t_conduit
	// Rising edges of both ticks over a fixed window
	task automatic t_ticks;
		logic [1:0] p;
		int n;
		int f;
		int s;
		f = 0;
		s = 0;
		p = pio_link_if_inst.dbg_status[12:11];
		for (n = 0; n < 400; n++)
		begin
			@(posedge clk_i);
			f += int'(pio_link_if_inst.dbg_status[11] === 1'h1 && p[0] === 1'h0);
			s += int'(pio_link_if_inst.dbg_status[12] === 1'h1 && p[1] === 1'h0);
			p = pio_link_if_inst.dbg_status[12:11];
		end
		chk_word(f, 16, "128ns ticks");
		chk_word(s, 2, "us ticks");
		$display("tick test done");
	endtask : t_ticks
	// Two writes, read back in turn; done interrupt masked and cleared
	task automatic t_mem;
		wr(pio_pkg::REG_MASK, 32'h00000001);
		wr(pio_pkg::REG_ADDR, 32'h00000100);
		wr(pio_pkg::REG_WDATA, 32'hA5A50F0F);
		run_cmd(32'h00000001);
		wr(pio_pkg::REG_ADDR, 32'h00000104);
		wr(pio_pkg::REG_WDATA, 32'h12345678);
		run_cmd(32'h00000001);
		wr(pio_pkg::REG_ADDR, 32'h00000100);
		run_cmd(32'h00000002);
		rd(pio_pkg::REG_RDATA, v);
		chk_word(v, 32'hA5A50F0F, "read 100");
		chk_word({31'h0, irq}, 32'h00000001, "irq set");
		wr(pio_pkg::REG_STATUS, 32'h00000001);
		repeat (2) @(posedge clk_i);
		chk_word({31'h0, irq}, 32'h00000000, "irq cleared");
		wr(pio_pkg::REG_MASK, 32'h00000000);
		wr(pio_pkg::REG_ADDR, 32'h00000104);
		run_cmd(32'h00000002);
		rd(pio_pkg::REG_RDATA, v);
		chk_word(v, 32'h12345678, "read 104");
		chk_word({31'h0, irq}, 32'h00000000, "irq masked");
		$display("memory test done");
	endtask : t_mem
	// Self test at 0x40, a command dropped while busy, an unmapped register
	task automatic t_self;
		logic e;
		wr(pio_pkg::REG_WDATA, 32'hC33C5AA5);
		run_cmd(32'h00000004);
		rd(pio_pkg::REG_STATUS, v);
		chk_word(v & 32'h00000007, 32'h00000003, "test pass");
		// Second command lands while the self test still waits for its completion
		wr(pio_pkg::REG_ADDR, 32'h00000100);
		wr(pio_pkg::REG_CMD, 32'h00000004);
		wr(pio_pkg::REG_CMD, 32'h00000001);
		repeat (10) @(posedge clk_i);
		run_cmd(32'h00000002);
		rd(pio_pkg::REG_RDATA, v);
		chk_word(v, 32'hA5A50F0F, "busy command dropped");
		wr(pio_pkg::REG_ADDR, 32'h00000040);
		run_cmd(32'h00000002);
		rd(pio_pkg::REG_RDATA, v);
		chk_word(v, 32'hC33C5AA5, "read 40");
		apb(1'h0, 8'h20, 32'h00000000, v, e);
		chk_word({e, v[30:0]}, 32'h80000000, "unmapped");
		$display("self test done");
	endtask : t_self
	// Main sequence
	initial
	begin
		bad_count = 0;
		comparisons = 0;
		rst_n_i = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		cs = '0;
		repeat (3) @(posedge clk_i);
		chk_bus(pio_link_if_inst.dbg_status, 256'h1 << 49, "status in reset");
		rst_n_i <= 1'h1;
		t_conduit();
		t_ticks();
		t_mem();
		t_self();
		final_report();
	end
endmodule : pio_endpoint_debug_conduit_tb
